// [hw/pll_refpath_pkg.sv]
// Constants for the reference path, detector and charge-pump configuration bank.
// Assumes a 32-bit APB slave with each register index at byte address index times four.
package pll_refpath_pkg;

	typedef logic [23:0] reg_word_t;

	localparam int REG_WIDTH  = 24;
	localparam int DATA_WIDTH = 32;
	localparam int ADDR_LSB   = 2;
	localparam int SYNC_STAGES = 3;

	// Register indices; the byte address is four times the index.
	localparam logic [3:0] IDX_REFERENCE_PATH_CONTROL = 4'h3;
	localparam logic [3:0] IDX_PRESCALER_DUTY_CONTROL = 4'h4;
	localparam logic [3:0] IDX_DETECTOR_POLARITY_MASK = 4'h5;
	localparam logic [3:0] IDX_DETECTOR_DELAY_CONTROL = 4'h6;
	localparam logic [3:0] IDX_PUMP_CURRENT_CONTROL   = 4'h7;
	localparam logic [3:0] IDX_PUMP_TRIM_OFFSET       = 4'h8;
	localparam logic [3:0] IDX_PUMP_FORCE_CONTROL     = 4'h9;
	localparam logic [3:0] IDX_RESERVED_A             = 4'ha;
	localparam logic [3:0] IDX_RESERVED_B             = 4'hb;
	localparam logic [3:0] IDX_RESERVED_C             = 4'hc;
	localparam logic [3:0] IDX_RESERVED_D             = 4'hd;
	localparam logic [3:0] IDX_RESERVED_E             = 4'he;
	localparam int         IDX_FIRST                  = 3;
	localparam int         IDX_LAST                   = 14;

	// Field positions.
	localparam int REF_RATIO_LSB  = 0;
	localparam int REF_RATIO_MSB  = 13;
	localparam int REF_SELECT_BIT = 14;
	localparam int REF_AUTO_BIT   = 15;
	localparam int REF_SINE_BIT   = 16;
	localparam int DUTY_MODE_BIT  = 0;
	localparam int POLARITY_BIT   = 0;
	localparam int UP_PASS_BIT    = 1;
	localparam int DOWN_PASS_BIT  = 2;
	localparam int DELAY_LSB      = 0;
	localparam int DELAY_MSB      = 2;
	localparam int UP_CUR_LSB     = 0;
	localparam int UP_CUR_MSB     = 4;
	localparam int DN_CUR_LSB     = 5;
	localparam int DN_CUR_MSB     = 9;
	localparam int UP_TRIM_LSB    = 0;
	localparam int UP_TRIM_MSB    = 3;
	localparam int DN_TRIM_LSB    = 4;
	localparam int DN_TRIM_MSB    = 7;
	localparam int UP_LEAK_LSB    = 8;
	localparam int UP_LEAK_MSB    = 11;
	localparam int DN_LEAK_LSB    = 12;
	localparam int DN_LEAK_MSB    = 15;
	localparam int BIAS_LSB       = 16;
	localparam int BIAS_MSB       = 17;
	localparam int FORCE_EN_BIT   = 0;
	localparam int FORCE_DIR_BIT  = 1;

	// Values after reset, indexed 3 to 14.
	localparam reg_word_t RESET_VALUES [IDX_FIRST:IDX_LAST] = '{
		24'h008001, 24'h000001, 24'h000006, 24'h000002, 24'h000210, 24'h020400,
		24'h000000, 24'h000304, 24'h000000, 24'h000100, 24'h000020, 24'h000000};

	// Implemented bits; the rest read as zero.
	localparam reg_word_t WRITE_MASKS [IDX_FIRST:IDX_LAST] = '{
		24'h01ffff, 24'h000001, 24'h000007, 24'h000007, 24'h0003ff, 24'h03ffff,
		24'h000003, 24'hffffff, 24'hffffff, 24'hffffff, 24'hffffff, 24'hffffff};

	localparam logic [13:0] RATIO_ONE = 14'h0001;

endpackage

// [hw/pll_refpath_regs.sv]
// Reference path, detector and charge-pump configuration bank with its small digital datapath.
// Assumes an APB master on pclk, crystal pins from outside the clock domain, and same-clock
// detector pulses and neighbouring enable bits.
//
// Function
// - Divide the selected crystal input by the 14-bit ratio when divider enabled and selected.
// - With auto selection clear, select bit routes the reference through the divider when set, bypasses it when clear.
// - With auto selection set, ratio one bypasses the divider, any other ratio uses it.
// - Sine select picks the sine reference; buffer enables must read binary 10 too.
// - Duty-mode bit lengthens prescaler low time from 30 to 94 cycles; advise zero.
// - Polarity bit inverts detector sense, swapping up and down toward the pump.
// - Up pulses reach the charge pump only while the up pass bit is set.
// - Down pulses reach the charge pump only while the down pass bit is set.
// - Three-bit detector delay code resets to two; software is advised to write one.
// - Five-bit up current code in 125 uA steps up to 4 mA.
// - Five-bit down current code in 125 uA steps up to 4 mA.
// - Four-bit up and down gain trim codes in 14.3 uA steps; advise zero.
// - Four-bit up and down leakage codes in 28.7 uA steps up to 430 uA.
// - Two-bit dummy-branch amplifier bias code; software is advised to write binary 10.
// - Force enable drives the pump continuously, up for direction zero, down for one.
// - Holding the divider in reset through its enable acts as bypassing it.
// - Sine buffer runs only with its enable bit and the sine select bit both set.
//
// Local design decision: the APB register port.
`timescale 1ns/1ns
module pll_refpath_regs #(
	parameter int ADDR_WIDTH  = 8,
	parameter int RATIO_WIDTH = 14
) (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   ce,
	input  wire logic [ADDR_WIDTH-1:0]  paddr,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [31:0]            pwdata,
	input  wire logic [3:0]             pstrb,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   ref_div_enable,
	input  wire logic                   square_buf_enable,
	input  wire logic                   sine_buf_enable,
	input  wire logic                   xtal_square_in,
	input  wire logic                   xtal_sine_in,
	input  wire logic                   pfd_up_raw,
	input  wire logic                   pfd_down_raw,
	output logic                        ref_clk_out,
	output logic                        ref_divider_active,
	output logic                        square_buffer_on,
	output logic                        sine_buffer_on,
	output logic                        prescaler_duty_extend,
	output logic      [2:0]             detector_delay_code,
	output logic      [4:0]             pump_up_current_code,
	output logic      [4:0]             pump_down_current_code,
	output logic      [3:0]             pump_up_trim_code,
	output logic      [3:0]             pump_down_trim_code,
	output logic      [3:0]             pump_up_leak_code,
	output logic      [3:0]             pump_down_leak_code,
	output logic      [1:0]             pump_dummy_amp_bias,
	output logic                        pump_up,
	output logic                        pump_down
);

	if (ADDR_WIDTH < 6 || ADDR_WIDTH > 31) begin : g_addr_check
		$error("ADDR_WIDTH must lie between 6 and 31");
	end
	if (RATIO_WIDTH != 14) begin : g_ratio_check
		$error("RATIO_WIDTH must be 14 to match the ratio field");
	end

	// Bus decode.
	function automatic logic addr_valid(input logic [ADDR_WIDTH-1:0] a);
		logic [3:0] i;
		i = a[5:2];
		return (a[1:0] == 2'h0) && (a[ADDR_WIDTH-1:6] == '0) &&
		       (i >= IDX3()) && (i <= IDX14());
	endfunction

	function automatic logic [3:0] IDX3();
		return pll_refpath_pkg::IDX_REFERENCE_PATH_CONTROL;
	endfunction

	function automatic logic [3:0] IDX14();
		return pll_refpath_pkg::IDX_RESERVED_E;
	endfunction

	pll_refpath_pkg::reg_word_t regs_reg [pll_refpath_pkg::IDX_FIRST:pll_refpath_pkg::IDX_LAST];
	logic                       ready_reg;
	logic [31:0]                prdata_reg;
	logic                       pslverr_reg;

	wire logic        access_phase = psel & penable;
	wire logic        first_access = access_phase & ~ready_reg;
	wire logic        hit          = addr_valid(paddr);
	wire logic [3:0]  index        = paddr[5:2];
	wire logic [23:0] lane_mask    = {{8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	wire logic [31:0] read_word    = hit ? {8'h00, regs_reg[index]} : 32'h00000000;
	wire logic        write_en     = pready & pwrite & hit;

	// A frozen clock enable also holds off the answer, so no write is lost while frozen.
	assign pready  = access_phase & ready_reg & ce;
	assign prdata  = prdata_reg;
	assign pslverr = pslverr_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_reg   <= 1'b0;
			prdata_reg  <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else if (ce) begin
			ready_reg <= first_access;
			if (first_access) begin
				prdata_reg  <= pwrite ? 32'h00000000 : read_word;
				pslverr_reg <= ~hit;
			end
		end
	end

	// Register storage: each word keeps only its implemented bits.
	for (genvar g = pll_refpath_pkg::IDX_FIRST; g <= pll_refpath_pkg::IDX_LAST; g++) begin : g_regs
		wire logic [23:0] reg_next = ((regs_reg[g] & ~lane_mask) | (pwdata[23:0] & lane_mask)) &
		                             pll_refpath_pkg::WRITE_MASKS[g];
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				regs_reg[g] <= pll_refpath_pkg::RESET_VALUES[g];
			end else if (write_en && index == 4'(g)) begin
				regs_reg[g] <= reg_next;
			end
		end
	end

	// Field views.
	wire logic [23:0] ref_word   = regs_reg[pll_refpath_pkg::IDX_REFERENCE_PATH_CONTROL];
	wire logic [23:0] pfd_word   = regs_reg[pll_refpath_pkg::IDX_DETECTOR_POLARITY_MASK];
	wire logic [23:0] cur_word   = regs_reg[pll_refpath_pkg::IDX_PUMP_CURRENT_CONTROL];
	wire logic [23:0] trim_word  = regs_reg[pll_refpath_pkg::IDX_PUMP_TRIM_OFFSET];
	wire logic [23:0] force_word = regs_reg[pll_refpath_pkg::IDX_PUMP_FORCE_CONTROL];

	wire logic [13:0] ratio      = ref_word[pll_refpath_pkg::REF_RATIO_MSB:pll_refpath_pkg::REF_RATIO_LSB];
	wire logic        div_select = ref_word[pll_refpath_pkg::REF_SELECT_BIT];
	wire logic        auto_sel   = ref_word[pll_refpath_pkg::REF_AUTO_BIT];
	wire logic        sine_sel   = ref_word[pll_refpath_pkg::REF_SINE_BIT];
	wire logic        polarity   = pfd_word[pll_refpath_pkg::POLARITY_BIT];
	wire logic        up_pass    = pfd_word[pll_refpath_pkg::UP_PASS_BIT];
	wire logic        down_pass  = pfd_word[pll_refpath_pkg::DOWN_PASS_BIT];
	wire logic        force_en   = force_word[pll_refpath_pkg::FORCE_EN_BIT];
	wire logic        force_dir  = force_word[pll_refpath_pkg::FORCE_DIR_BIT];

	assign prescaler_duty_extend = regs_reg[pll_refpath_pkg::IDX_PRESCALER_DUTY_CONTROL][pll_refpath_pkg::DUTY_MODE_BIT];
	assign detector_delay_code   = regs_reg[pll_refpath_pkg::IDX_DETECTOR_DELAY_CONTROL][pll_refpath_pkg::DELAY_MSB:pll_refpath_pkg::DELAY_LSB];
	assign pump_up_current_code   = cur_word[pll_refpath_pkg::UP_CUR_MSB:pll_refpath_pkg::UP_CUR_LSB];
	assign pump_down_current_code = cur_word[pll_refpath_pkg::DN_CUR_MSB:pll_refpath_pkg::DN_CUR_LSB];
	assign pump_up_trim_code      = trim_word[pll_refpath_pkg::UP_TRIM_MSB:pll_refpath_pkg::UP_TRIM_LSB];
	assign pump_down_trim_code    = trim_word[pll_refpath_pkg::DN_TRIM_MSB:pll_refpath_pkg::DN_TRIM_LSB];
	assign pump_up_leak_code      = trim_word[pll_refpath_pkg::UP_LEAK_MSB:pll_refpath_pkg::UP_LEAK_LSB];
	assign pump_down_leak_code    = trim_word[pll_refpath_pkg::DN_LEAK_MSB:pll_refpath_pkg::DN_LEAK_LSB];
	assign pump_dummy_amp_bias    = trim_word[pll_refpath_pkg::BIAS_MSB:pll_refpath_pkg::BIAS_LSB];

	// Reference buffers: the sine buffer needs its enable with the square enable off.
	wire logic sine_path   = sine_sel & sine_buf_enable & ~square_buf_enable;
	wire logic square_path = ~sine_sel & square_buf_enable;
	assign sine_buffer_on   = sine_path;
	assign square_buffer_on = square_path;

	// Crystal pins: three flops, a level change counts once stages two and three agree.
	wire logic [1:0]  xtal_pins = {xtal_sine_in, xtal_square_in};
	logic      [1:0]  xtal_level_reg;
	logic      [1:0]  xtal_rise;
	for (genvar p = 0; p < 2; p++) begin : g_sync
		logic [pll_refpath_pkg::SYNC_STAGES-1:0] sync_reg;
		wire logic agree = (sync_reg[1] == sync_reg[2]);
		assign xtal_rise[p] = agree & sync_reg[2] & ~xtal_level_reg[p];
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				sync_reg          <= '0;
				xtal_level_reg[p] <= 1'b0;
			end else if (ce) begin
				sync_reg <= {sync_reg[1:0], xtal_pins[p]};
				if (agree) begin
					xtal_level_reg[p] <= sync_reg[2];
				end
			end
		end
	end

	wire logic sel_level = sine_path ? xtal_level_reg[1] : (square_path & xtal_level_reg[0]);
	wire logic sel_rise  = sine_path ? xtal_rise[1] : (square_path & xtal_rise[0]);

	// Divider use: enable low holds the counter in reset, which is the bypass.
	wire logic div_wanted = auto_sel ? (ratio != pll_refpath_pkg::RATIO_ONE) : div_select;
	wire logic div_active = ref_div_enable & div_wanted;
	assign ref_divider_active = div_active;

	logic [13:0] div_cnt_reg;
	logic        ref_out_reg;
	wire  logic [13:0] ratio_last = ratio - 14'h0001;
	wire  logic [13:0] half_ratio = {1'b0, ratio[13:1]};
	// A zero ratio is illegal; the counter wraps through the longest count, but the output stays stuck low.
	wire  logic [13:0] div_cnt_next = (div_cnt_reg >= ratio_last && ratio != 14'h0000) ? 14'h0000
	                                  : div_cnt_reg + 14'h0001;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_reg <= 14'h0000;
		end else if (ce) begin
			if (!div_active) begin
				div_cnt_reg <= 14'h0000;
			end else if (sel_rise) begin
				div_cnt_reg <= div_cnt_next;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_out_reg <= 1'b0;
		end else if (ce) begin
			ref_out_reg <= div_active ? (div_cnt_reg < half_ratio) : sel_level;
		end
	end
	assign ref_clk_out = ref_out_reg;

	// Detector to pump: polarity swap, masking, then the force override.
	wire logic det_up   = polarity ? pfd_down_raw : pfd_up_raw;
	wire logic det_down = polarity ? pfd_up_raw : pfd_down_raw;
	wire logic up_next   = force_en ? ~force_dir : (det_up & up_pass);
	wire logic down_next = force_en ? force_dir : (det_down & down_pass);

	logic pump_up_reg;
	logic pump_down_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pump_up_reg   <= 1'b0;
			pump_down_reg <= 1'b0;
		end else if (ce) begin
			pump_up_reg   <= up_next;
			pump_down_reg <= down_next;
		end
	end
	assign pump_up   = pump_up_reg;
	assign pump_down = pump_down_reg;

	// Checks.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_write_reads_back: assert property (
		write_en && pstrb[2:0] == 3'h7 |=> regs_reg[$past(index)] ==
			($past(pwdata[23:0]) & pll_refpath_pkg::WRITE_MASKS[$past(index)]))
		else $error("register did not take the written value");

	a_read_returns_reg: assert property (
		pready && !pwrite && hit |-> prdata == {8'h00, regs_reg[index]})
		else $error("read data differs from register content");

	a_unmapped_error: assert property (
		pready && !hit |-> pslverr && !$past(write_en))
		else $error("unmapped access not flagged");

	a_access_two_cycles: assert property (
		psel && !penable && ce ##1 access_phase && ce ##1 access_phase && ce |-> pready)
		else $error("slave did not answer in the second access cycle");

	a_auto_bypass_one: assert property (
		auto_sel && ratio == pll_refpath_pkg::RATIO_ONE |-> !ref_divider_active)
		else $error("divider used although ratio is one under auto selection");

	a_manual_select: assert property (
		!auto_sel && ref_div_enable |-> ref_divider_active == div_select)
		else $error("divider routing does not follow the select bit");

	a_enable_bypass: assert property (
		!ref_div_enable && ce |-> !ref_divider_active ##1 div_cnt_reg == 14'h0000)
		else $error("divider not held in reset while disabled");

	a_count_in_range: assert property (
		ref_divider_active && ratio >= 14'h0002 && $stable(ratio) && ce |=> div_cnt_reg < ratio || $changed(ratio))
		else $error("divider count ran past the ratio");

	a_sine_needs_enable: assert property (
		sine_buffer_on |-> sine_buf_enable && sine_sel && !square_buffer_on)
		else $error("sine buffer on without its enables");

	a_up_masked: assert property (
		ce && !force_en && !up_pass |=> !pump_up)
		else $error("up pulse passed while masked");

	a_down_masked: assert property (
		ce && !force_en && !down_pass |=> !pump_down)
		else $error("down pulse passed while masked");

	a_polarity_swap: assert property (
		ce && !force_en && polarity && up_pass && down_pass |=>
			pump_up == $past(pfd_down_raw) && pump_down == $past(pfd_up_raw))
		else $error("polarity inversion not applied");

	a_force_direction: assert property (
		ce && force_en ##1 ce && $stable(force_word) |-> pump_up == !force_dir && pump_down == force_dir)
		else $error("forced pump direction wrong");

	c_write_then_read: cover property (write_en ##[1:8] (pready && !pwrite && hit));
	c_divider_running: cover property (ref_divider_active && sel_rise && div_cnt_reg == ratio_last);
	c_force_down: cover property (force_en && force_dir && pump_down);
	c_unmapped: cover property (pready && pslverr);

endmodule // pll_refpath_regs

// [sim/tb_pll_refpath_regs.sv]
// Self-checking bench for the reference path, detector and charge-pump configuration bank.
// Assumes a single pclk domain and that the bank answers APB with at least one wait state.
`timescale 1ns/1ns
module tb_pll_refpath_regs;
	logic        pclk;
	logic        presetn;
	logic        ce;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ref_div_enable;
	logic        square_buf_enable;
	logic        sine_buf_enable;
	logic        xtal;
	logic        up_raw;
	logic        down_raw;
	logic        ref_clk_out;
	logic        ref_divider_active;
	logic        square_buffer_on;
	logic        sine_buffer_on;
	logic        prescaler_duty_extend;
	logic [2:0]  detector_delay_code;
	logic [4:0]  up_cur;
	logic [4:0]  dn_cur;
	logic [3:0]  up_trim;
	logic [3:0]  dn_trim;
	logic [3:0]  up_leak;
	logic [3:0]  dn_leak;
	logic [1:0]  amp_bias;
	logic        pump_up;
	logic        pump_down;
	logic [31:0] rd;
	logic        err;
	logic        u;
	logic        d;
	int          errors;
	int          checks_done;
	int          rises;

	localparam logic [23:0] RST [3:14] = '{24'h008001, 24'h000001, 24'h000006, 24'h000002, 24'h000210,
		24'h020400, 24'h000000, 24'h000304, 24'h000000, 24'h000100, 24'h000020, 24'h000000};
	localparam logic [23:0] MSK [3:14] = '{24'h01ffff, 24'h000001, 24'h000007, 24'h000007, 24'h0003ff,
		24'h03ffff, 24'h000003, 24'hffffff, 24'hffffff, 24'hffffff, 24'hffffff, 24'hffffff};

	pll_refpath_regs u_pll_refpath_regs (
		.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ref_div_enable(ref_div_enable), .square_buf_enable(square_buf_enable),
		.sine_buf_enable(sine_buf_enable), .xtal_square_in(xtal), .xtal_sine_in(xtal),
		.pfd_up_raw(up_raw), .pfd_down_raw(down_raw), .ref_clk_out(ref_clk_out),
		.ref_divider_active(ref_divider_active), .square_buffer_on(square_buffer_on),
		.sine_buffer_on(sine_buffer_on), .prescaler_duty_extend(prescaler_duty_extend),
		.detector_delay_code(detector_delay_code), .pump_up_current_code(up_cur),
		.pump_down_current_code(dn_cur), .pump_up_trim_code(up_trim), .pump_down_trim_code(dn_trim),
		.pump_up_leak_code(up_leak), .pump_down_leak_code(dn_leak), .pump_dummy_amp_bias(amp_bias),
		.pump_up(pump_up), .pump_down(pump_down));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Samples pready at the rising edge; the trailing falling edge lets a write settle before checks.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= dt;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 100) chk("pready", 32'h0, 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] dt);
		apb(1'b1, a, dt, 4'hf);
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [23:0] e);
		apb(1'b0, a, 32'h0, 4'hf);
		chk(nm, rd, {8'h00, e});
		chk("read_error", {31'h0, err}, 32'h0);
	endtask

	task automatic div_case(input logic en, input logic [31:0] r3, input logic e);
		@(posedge pclk);
		ref_div_enable <= en;
		wr(8'h0c, r3);
		@(negedge pclk);
		chk("divider_active", {31'h0, ref_divider_active}, {31'h0, e});
	endtask

	// Counts reference output rises over n crystal periods of eight pclk cycles each.
	task automatic count(input int n, output int r);
		logic prev;
		prev = ref_clk_out;
		r = 0;
		for (int i = 0; i < n * 8; i++) begin
			@(posedge pclk);
			xtal <= (i % 8) < 4;
			@(negedge pclk);
			if (ref_clk_out === 1'b1 && prev !== 1'b1) r++;
			prev = ref_clk_out;
		end
	endtask

	initial begin
		#500000;
		errors++;
		report_and_stop();
	end

	initial begin
		{presetn, psel, penable, pwrite, up_raw, down_raw, xtal, sine_buf_enable} = 8'h00;
		{ce, ref_div_enable, square_buf_enable} = 3'b111;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hf;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 3; i <= 14; i++) rchk("reset_value", 8'(i * 4), RST[i]);
		chk("duty_extend", {31'h0, prescaler_duty_extend}, 32'h1);
		chk("delay_code", {29'h0, detector_delay_code}, 32'h2);
		apb(1'b0, 8'h00, 32'h0, 4'hf);
		chk("unmapped_error", {31'h0, err}, 32'h1);
		chk("unmapped_data", rd, 32'h0);
		apb(1'b1, 8'h29, 32'hffffff, 4'hf);
		chk("misaligned_error", {31'h0, err}, 32'h1);
		rchk("reserved_a", 8'h28, 24'h000304);
		apb(1'b1, 8'h2c, 32'hffffff, 4'h2);
		rchk("strobe_lane", 8'h2c, 24'h00ff00);
		for (int i = 3; i <= 14; i++) begin
			wr(8'(i * 4), 32'hffffffff);
			rchk("all_ones", 8'(i * 4), MSK[i]);
			wr(8'(i * 4), {8'h00, RST[i]});
		end
		wr(8'h18, 32'h1);
		chk("delay_code", {29'h0, detector_delay_code}, 32'h1);
		wr(8'h10, 32'h0);
		chk("duty_extend", {31'h0, prescaler_duty_extend}, 32'h0);
		wr(8'h1c, 32'h3e1);
		chk("up_current", {27'h0, up_cur}, 32'h01);
		chk("down_current", {27'h0, dn_cur}, 32'h1f);
		wr(8'h20, 32'h29c5a);
		chk("trims", {24'h0, dn_trim, up_trim}, 32'h5a);
		chk("leaks", {24'h0, dn_leak, up_leak}, 32'h9c);
		chk("amp_bias", {30'h0, amp_bias}, 32'h2);
		for (int c = 0; c < 32; c++) begin
			wr(8'h14, 32'(c[2:0]));
			@(posedge pclk);
			up_raw <= c[3];
			down_raw <= c[4];
			@(posedge pclk);
			@(negedge pclk);
			u = c[0] ? c[4] : c[3];
			d = c[0] ? c[3] : c[4];
			chk("pump_up", {31'h0, pump_up}, {31'h0, u & c[1]});
			chk("pump_down", {31'h0, pump_down}, {31'h0, d & c[2]});
		end
		wr(8'h14, 32'h0);
		for (int f = 1; f <= 3; f += 2) begin
			wr(8'h24, 32'(f));
			@(posedge pclk);
			@(negedge pclk);
			chk("forced_up", {31'h0, pump_up}, 32'(f == 1));
			chk("forced_down", {31'h0, pump_down}, 32'(f == 3));
		end
		wr(8'h24, 32'h0);
		div_case(1'b1, 32'h008001, 1'b0);
		div_case(1'b1, 32'h008004, 1'b1);
		div_case(1'b1, 32'h00c001, 1'b0);
		div_case(1'b1, 32'h004004, 1'b1);
		div_case(1'b1, 32'h000004, 1'b0);
		div_case(1'b0, 32'h004004, 1'b0);
		for (int b = 0; b < 8; b++) begin
			@(posedge pclk);
			square_buf_enable <= b[0];
			sine_buf_enable <= b[1];
			wr(8'h0c, 32'({b[2], 16'h4004}));
			@(negedge pclk);
			chk("square_buffer", {31'h0, square_buffer_on}, {31'h0, !b[2] & b[0]});
			chk("sine_buffer", {31'h0, sine_buffer_on}, {31'h0, b[2] & b[1] & !b[0]});
		end
		sine_buf_enable <= 1'b0;
		div_case(1'b1, 32'h004004, 1'b1);
		count(8, rises);
		count(32, rises);
		chk("divided_rises", 32'(rises), 32'd8);
		div_case(1'b1, 32'h008001, 1'b0);
		count(8, rises);
		count(32, rises);
		chk("bypass_rises", 32'(rises), 32'd32);
		div_case(1'b0, 32'h004004, 1'b0);
		count(8, rises);
		count(32, rises);
		chk("held_rises", 32'(rises), 32'd32);
		report_and_stop();
	end
endmodule // tb_pll_refpath_regs
